// File: hw/abs_enc_cfg.sv
// Top: absolute encoder configuration, frame capture and ratio scaling
`timescale 1ns/1ns
module abs_enc_cfg
    import abs_enc_pkg::*;
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST,
    // Configuration
    input wire logic [7:0] I_AXIS_TYPE,
    input wire logic [LAYOUT_W-1:0] I_LAYOUT,
    input wire logic I_MODE,
    input wire logic [RATIO_W-1:0] I_RATIO_NUM,
    input wire logic [RATIO_W-1:0] I_RATIO_DEN,
    input wire logic I_RATIO_WR,
    // Encoder link
    input wire logic I_ENC_CLK,
    input wire logic I_ENC_DATA,
    input wire logic I_ENC_FRAME,
    // Position offset and define
    input wire logic I_POS_OFFSET_CMD,
    input wire logic I_POS_DEFINE_CMD,
    input wire logic [POS_W-1:0] I_POS_VALUE,
    // Status
    output logic O_MODE_PARAM,
    output logic O_RATIO_REJECT,
    output logic [WORD_W-1:0] O_RAW,
    output logic [WORD_W-1:0] O_TURNS,
    output logic [POS_W-1:0] O_MEASURED_POSITION,
    output logic O_SAMPLE
);
    // ==========================================
    // Layout latch
    logic [7:0] type_prev_ff;
    logic [LAYOUT_W-1:0] layout_ff;
    // Layout captured when axis type changes, so software must set it first
    wire logic type_change = (I_AXIS_TYPE != type_prev_ff);
    wire logic is_bidir = (I_AXIS_TYPE == AXIS_TYPE_BIDIR);
    wire logic is_ssi = (I_AXIS_TYPE == AXIS_TYPE_SSI);
    wire logic is_abs = is_bidir || is_ssi;
    layout_s lay;
    always_comb begin
        lay = '0;
        lay.active = is_abs;
        lay.bidir = is_bidir;
        if (is_bidir) begin
            lay.len = layout_ff[BD_LEN_LSB +: BD_LEN_W];
            lay.turn_bits = layout_ff[BD_TURN_LSB +: BD_TURN_W];
        end else if (is_ssi) begin
            lay.len = 8'(layout_ff[SSI_LEN_LSB +: SSI_LEN_W]);
            lay.binary = layout_ff[SSI_BIN_BIT];
            lay.shift = layout_ff[SSI_SHIFT_LSB +: SSI_SHIFT_W];
        end
    end
    // Track type and capture layout on change
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            type_prev_ff <= 8'h00;
            layout_ff <= LAYOUT_RESET;
        end else begin
            type_prev_ff <= I_AXIS_TYPE;
            if (type_change) begin
                layout_ff <= I_LAYOUT;
            end
        end
    end
    // ==========================================
    // Mode control: cyclic after reset, bidirectional only
    logic mode_ff;
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            mode_ff <= MODE_CYCLIC;
        end else if (is_bidir) begin
            mode_ff <= I_MODE;
        end else begin
            mode_ff <= MODE_CYCLIC;
        end
    end
    assign O_MODE_PARAM = (mode_ff == MODE_PARAM);
    // ==========================================
    // Ratio registers
    logic [RATIO_W-1:0] num_ff;
    logic [RATIO_W-1:0] den_ff;
    logic reject_ff;
    wire logic den_zero = (I_RATIO_DEN == '0);
    // Zero denominator would divide by zero; keep old pair instead
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            num_ff <= RATIO_RESET;
            den_ff <= RATIO_RESET;
            reject_ff <= 1'b0;
        end else if (I_RATIO_WR) begin
            reject_ff <= den_zero;
            if (!den_zero) begin
                num_ff <= I_RATIO_NUM;
                den_ff <= I_RATIO_DEN;
            end
        end
    end
    assign O_RATIO_REJECT = reject_ff;
    // ==========================================
    // Link synchronisers (two flops each)
    // Only the second flop feeds logic; the first may still be settling.
    // Bit 0 is the link clock, bit 1 the data line, bit 2 the frame line.
    // Clock and data share one pipe, so a bit sampled on a rise is aligned.
    logic [2:0] s1_ff;
    logic [2:0] s2_ff;
    logic clk_d_ff;
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            s1_ff <= 3'h0;
            s2_ff <= 3'h0;
            clk_d_ff <= 1'b0;
        end else begin
            s1_ff <= {I_ENC_FRAME, I_ENC_DATA, I_ENC_CLK};
            s2_ff <= s1_ff;
            clk_d_ff <= s2_ff[0];
        end
    end
    wire logic enc_rise = s2_ff[0] && !clk_d_ff;
    wire logic frame_on = s2_ff[2];
    // ==========================================
    // Frame shift register, MSB first; ignored in parameter mode
    logic [WORD_W-1:0] shreg_ff;
    logic frame_d_ff;
    wire logic frame_end = frame_d_ff && !frame_on;
    wire logic capture_ok = is_abs && (mode_ff == MODE_CYCLIC);
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            shreg_ff <= '0;
            frame_d_ff <= 1'b0;
        end else begin
            frame_d_ff <= frame_on;
            if (frame_on && !frame_d_ff) begin
                shreg_ff <= '0;
            end else if (frame_on && enc_rise) begin
                shreg_ff <= {shreg_ff[WORD_W-2:0], s2_ff[1]};
            end
        end
    end
    // ==========================================
    // Word decode
    logic [WORD_W-1:0] raw_w;
    logic [WORD_W-1:0] turns_w;
    abs_enc_word u_word (
        .i_layout(lay),
        .i_word(shreg_ff),
        .o_raw(raw_w),
        .o_turns(turns_w)
    );
    // ==========================================
    // Raw, turns and scaled position
    logic [WORD_W-1:0] raw_ff; // Last decoded word
    logic [WORD_W-1:0] turns_ff; // Last turn count, zero off bidirectional axes
    logic [POS_W-1:0] pos_ff; // Scaled single-turn position
    logic [POS_W-1:0] offset_ff; // Software offset added to the position
    logic [POS_W-1:0] meas_ff; // Registered sum shown on the port
    logic sample_ff; // One-cycle new-sample pulse
    // Single-turn width: the bits that sit below the turn field
    wire logic [7:0] st_bits = lay.len - 8'(lay.turn_bits);
    // Turn field removed before scaling; software adds it by offset or define.
    // Turns are zero off bidirectional axes, so the whole word passes there.
    wire logic [WORD_W-1:0] single_w = raw_w ^ (turns_w << st_bits);
    // A frame counts only on an absolute axis in cyclic mode
    wire logic take = frame_end && capture_ok;
    // Wide product avoids overflow before the divide; the price is a big divider
    wire logic [WORD_W+RATIO_W-1:0] prod = single_w * num_ff;
    wire logic [WORD_W+RATIO_W-1:0] quot = prod / den_ff;
    // Position port is narrower than the quotient: keep the low bits on purpose
    wire logic [POS_W-1:0] scaled = quot[POS_W-1:0];
    // Capture raw word and scaled position when a cyclic frame closes
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            raw_ff <= '0;
            pos_ff <= '0;
            sample_ff <= 1'b0;
        end else begin
            sample_ff <= take;
            if (take) begin
                raw_ff <= raw_w;
                pos_ff <= scaled;
            end
        end
    end
    // Turn count follows frames and reads zero while the axis is not bidirectional
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            turns_ff <= '0;
        end else if (!is_bidir) begin
            // Cleared at once, so a type change never shows a stale count
            turns_ff <= '0;
        end else if (take) begin
            turns_ff <= turns_w;
        end
    end
    // Offset moves only on software command, never on a frame
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            offset_ff <= '0;
        end else if (I_POS_DEFINE_CMD) begin
            // Define makes the shown position equal the given value
            offset_ff <= I_POS_VALUE - pos_ff;
        end else if (I_POS_OFFSET_CMD) begin
            // Offset shifts the shown position by the given amount
            offset_ff <= offset_ff + I_POS_VALUE;
        end
    end
    // Registered sum keeps the port off the adder; costs one cycle of lag
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            meas_ff <= '0;
        end else begin
            meas_ff <= pos_ff + offset_ff;
        end
    end
    assign O_RAW = raw_ff;
    assign O_TURNS = turns_ff;
    assign O_MEASURED_POSITION = meas_ff;
    assign O_SAMPLE = sample_ff;
endmodule

// File: include/abs_enc_pkg.sv
// Package: constants, types and field layout for the absolute encoder configuration block
package abs_enc_pkg;
    // ==========================================
    // Axis types
    localparam logic [7:0] AXIS_TYPE_BIDIR = 8'h2f;  // 47
    localparam logic [7:0] AXIS_TYPE_SSI = 8'h30;    // 48
    // ==========================================
    // Layout field positions
    localparam int BD_LEN_LSB = 0;
    localparam int BD_LEN_W = 8;
    localparam int BD_TURN_LSB = 8;
    localparam int BD_TURN_W = 7;
    localparam int SSI_LEN_LSB = 0;
    localparam int SSI_LEN_W = 6;
    localparam int SSI_BIN_BIT = 6;
    localparam int SSI_SHIFT_LSB = 8;
    localparam int SSI_SHIFT_W = 3;
    localparam int LAYOUT_W = 16;
    // ==========================================
    // Mode and scaling
    localparam logic MODE_CYCLIC = 1'b0;
    localparam logic MODE_PARAM = 1'b1;
    localparam int RATIO_W = 24;                     // Up to 16777215
    localparam logic [23:0] RATIO_RESET = 24'h000001;
    localparam int WORD_W = 64;                      // Widest received word
    localparam int POS_W = 32;
    localparam logic [15:0] LAYOUT_RESET = 16'h0000;
    // Decoded layout carried between modules
    typedef struct packed {
        logic       active;
        logic       bidir;
        logic [7:0] len;
        logic [6:0] turn_bits;
        logic       binary;
        logic [2:0] shift;
    } layout_s;
endpackage

// File: hw/abs_enc_word.sv
// Word decoder: turns a received frame into raw position and turn count
`timescale 1ns/1ns
module abs_enc_word
    import abs_enc_pkg::*;
(
    // Decoded layout and received frame
    input wire layout_s i_layout,
    input wire logic [WORD_W-1:0] i_word,
    // Decoded results
    output logic [WORD_W-1:0] o_raw,
    output logic [WORD_W-1:0] o_turns
);
    // Low-bit mask of the given length
    function automatic logic [WORD_W-1:0] len_mask(input logic [7:0] n);
        logic [WORD_W-1:0] m;
        m = '0;
        for (int k = 0; k < WORD_W; k++) begin
            m[k] = (k < n);
        end
        return m;
    endfunction
    // Extra shift then trim to programmed length
    wire logic [WORD_W-1:0] shifted = i_layout.bidir ? i_word : (i_word >> i_layout.shift);
    wire logic [WORD_W-1:0] trimmed = shifted & len_mask(i_layout.len);
    logic [WORD_W-1:0] gray_bin;
    // Gray to binary: each bit is xor of its own bit and all higher bits
    always_comb begin
        gray_bin = '0;
        // Top bit passes straight, so the loop never indexes past the word
        gray_bin[WORD_W-1] = trimmed[WORD_W-1];
        for (int k = WORD_W - 2; k >= 0; k--) begin
            gray_bin[k] = trimmed[k] ^ gray_bin[k+1];
        end
    end
    wire logic use_gray = !i_layout.bidir && !i_layout.binary;
    wire logic [7:0] st_bits = i_layout.len - 8'(i_layout.turn_bits);
    assign o_raw = use_gray ? gray_bin : trimmed;
    // Turn count sits above single-turn bits, bidirectional only
    assign o_turns = i_layout.bidir ? ((trimmed >> st_bits) & len_mask(8'(i_layout.turn_bits))) : '0;
endmodule

// File: testbench/abs_enc_cfg_assertions.sv
// Checker: port-level properties of the absolute encoder block
`timescale 1ns/1ns
module abs_enc_cfg_assertions
    import abs_enc_pkg::*;
(
    // Clock, reset and controls
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic [7:0] I_AXIS_TYPE,
    input wire logic I_MODE,
    input wire logic [RATIO_W-1:0] I_RATIO_DEN,
    input wire logic I_RATIO_WR,
    input wire logic I_ENC_FRAME,
    // Status outputs
    input wire logic O_MODE_PARAM,
    input wire logic O_RATIO_REJECT,
    input wire logic [WORD_W-1:0] O_RAW,
    input wire logic [WORD_W-1:0] O_TURNS,
    input wire logic O_SAMPLE
);
    // ====
    // One domain, so clock and reset are given once
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    wire bidir = I_AXIS_TYPE == AXIS_TYPE_BIDIR;
    wire absolute = bidir || (I_AXIS_TYPE == AXIS_TYPE_SSI);
    // Frame close on an SSI axis, then the sample within the sync delay
    sequence ssi_end_s;
        $fell(I_ENC_FRAME) && (I_AXIS_TYPE == AXIS_TYPE_SSI);
    endsequence
    sequence sample_s;
        ##[1:8] O_SAMPLE;
    endsequence
    frame_sample_a: assert property (ssi_end_s |-> sample_s)
        else $error("no sample after frame");
    sample_pulse_a: assert property (O_SAMPLE |=> !O_SAMPLE)
        else $error("sample longer than one cycle");
    idle_type_a: assert property ((!absolute)[*8] |-> !O_SAMPLE)
        else $error("sample on non-absolute axis");
    turns_zero_a: assert property ((!bidir)[*2] |-> O_TURNS == '0)
        else $error("turn count not zero");
    reject_set_a: assert property (I_RATIO_WR && I_RATIO_DEN == '0 |=> O_RATIO_REJECT)
        else $error("zero divisor not refused");
    reject_clr_a: assert property (I_RATIO_WR && I_RATIO_DEN != '0 |=> !O_RATIO_REJECT)
        else $error("good ratio refused");
    reject_hold_a: assert property (!I_RATIO_WR |=> $stable(O_RATIO_REJECT))
        else $error("reject flag moved without write");
    mode_on_a: assert property ((bidir && I_MODE)[*3] |-> O_MODE_PARAM)
        else $error("parameter mode missing");
    mode_off_a: assert property ((!bidir || !I_MODE)[*3] |-> !O_MODE_PARAM)
        else $error("parameter mode stray");
    raw_hold_a: assert property ($changed(O_RAW) |-> O_SAMPLE)
        else $error("raw value moved without sample");
endmodule
bind abs_enc_cfg abs_enc_cfg_assertions chk_u (.I_CLK, .I_RST, .I_AXIS_TYPE, .I_MODE,
    .I_RATIO_DEN, .I_RATIO_WR, .I_ENC_FRAME, .O_MODE_PARAM, .O_RATIO_REJECT, .O_RAW,
    .O_TURNS, .O_SAMPLE);

// File: testbench/abs_enc_model.sv
// Encoder model: sends one MSB-first word per frame on a 160 ns link clock
`timescale 1ns/1ns
module abs_enc_model (
    // Link pins
    output logic o_clk,
    output logic o_data,
    output logic o_frame
);
    // ====
    // Link clock stands low outside frames
    initial begin
        o_clk = 1'b0;
        o_data = 1'b0;
        o_frame = 1'b0;
    end
    // Odd offset keeps link edges off the block clock's phase
    task automatic send(input logic [63:0] w, input int n);
        #3 o_frame = 1'b1;
        #80;
        for (int i = n - 1; i >= 0; i--) begin
            o_data = w[i];
            #80 o_clk = 1'b1;
            #80 o_clk = 1'b0;
        end
        #80 o_frame = 1'b0;
        // Released line shows the inverse, not a stale bit
        o_data = ~o_data;
    endtask
endmodule

// File: testbench/absolute_encoder_config_tb_top.sv
// Testbench: absolute encoder block against the encoder model
`timescale 1ns/1ns
module absolute_encoder_config_tb_top;
    import abs_enc_pkg::*;
    // ====
    logic clk = 1'b0;
    logic rst, mode, wr, eclk, edat, efrm, mode_p, rej, smp, ofs, dfn;
    logic [31:0] pval;
    logic [7:0] axis_type;
    logic [15:0] layout;
    logic [23:0] num, den;
    logic [63:0] raw, turns;
    logic [31:0] pos;
    int errors = 0;
    int check_count = 0;
    int samples = 0;
    always #5 clk = ~clk;
    // Sample pulses counted so lost or extra frames show
    always @(posedge clk) if (smp === 1'b1) samples++;
    abs_enc_model enc_u (.o_clk(eclk), .o_data(edat), .o_frame(efrm));
    // Offset and define driven by the bidirectional scenario
    abs_enc_cfg dut_u (.I_CLK(clk), .I_RST(rst), .I_AXIS_TYPE(axis_type), .I_LAYOUT(layout),
        .I_MODE(mode), .I_RATIO_NUM(num), .I_RATIO_DEN(den), .I_RATIO_WR(wr),
        .I_ENC_CLK(eclk), .I_ENC_DATA(edat), .I_ENC_FRAME(efrm), .I_POS_OFFSET_CMD(ofs),
        .I_POS_DEFINE_CMD(dfn), .I_POS_VALUE(pval), .O_MODE_PARAM(mode_p),
        .O_RATIO_REJECT(rej), .O_RAW(raw), .O_TURNS(turns), .O_MEASURED_POSITION(pos),
        .O_SAMPLE(smp));
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic logic [63:0] gray(input logic [63:0] g);
        gray = g;
        for (int i = 62; i >= 0; i--) gray[i] = gray[i+1] ^ g[i];
    endfunction
    // Layout first, then the type change that latches it
    task automatic cfg(input logic [7:0] t, input logic [15:0] l);
        @(negedge clk) axis_type = 8'h00;
        layout = l;
        @(negedge clk) axis_type = t;
        repeat (2) @(negedge clk);
    endtask
    task automatic frame(input logic [63:0] w, input int n, input int exp_n);
        int s0;
        s0 = samples;
        @(negedge clk) enc_u.send(w, n);
        repeat (12) @(negedge clk);
        check("sample count", 64'(samples - s0), 64'(exp_n));
    endtask
    task automatic ratio(input logic [23:0] n, input logic [23:0] d, input logic r);
        @(negedge clk) num = n;
        den = d;
        wr = 1'b1;
        @(negedge clk) wr = 1'b0;
        @(negedge clk) check("reject", 64'(rej), 64'(r));
    endtask
    task automatic t_ssi();
        cfg(AXIS_TYPE_SSI, 16'h034c);
        frame(64'hda5c, 16, 1);
        check("ssi raw", raw, 64'hb4b);
        check("ssi turns", turns, 64'h0);
        check("ssi position", 64'(pos), 64'hb4b);
        cfg(AXIS_TYPE_SSI, 16'h000c);
        frame(64'hb3c, 12, 1);
        check("gray raw", raw, gray(64'hb3c));
    endtask
    task automatic t_bidir();
        cfg(AXIS_TYPE_BIDIR, 16'h0c19);
        frame(64'h1abcdef, 25, 1);
        check("bidir raw", raw, 64'h1abcdef);
        check("bidir turns", turns, 64'hd5e);
        check("bidir position", 64'(pos), 64'hdef);
        @(negedge clk) pval = 32'h1000;
        ofs = 1'b1;
        @(negedge clk) ofs = 1'b0;
        repeat (2) @(negedge clk);
        check("offset position", 64'(pos), 64'h1def);
        @(negedge clk) pval = 32'hdef;
        dfn = 1'b1;
        @(negedge clk) dfn = 1'b0;
        repeat (2) @(negedge clk);
        check("defined position", 64'(pos), 64'hdef);
        @(negedge clk) mode = MODE_PARAM;
        repeat (3) @(negedge clk);
        check("param mode", 64'(mode_p), 64'h1);
        frame(64'h5, 25, 0);
        @(negedge clk) mode = MODE_CYCLIC;
        repeat (3) @(negedge clk);
        check("cyclic mode", 64'(mode_p), 64'h0);
    endtask
    task automatic t_other();
        cfg(8'h04, 16'h000c);
        frame(64'h123, 12, 0);
        check("other turns", turns, 64'h0);
        check("other raw", raw, 64'h1abcdef);
    endtask
    task automatic t_scale();
        ratio(24'h3, 24'h2, 1'b0);
        ratio(24'h5, 24'h0, 1'b1);
        cfg(AXIS_TYPE_SSI, 16'h004c);
        frame(64'h100, 12, 1);
        check("scaled position", 64'(pos), 64'h180);
    endtask
    // Watchdog well past the few frames of the run
    initial begin
        #200000;
        errors++;
        print_verdict();
    end
    initial begin
        rst = 1'b1;
        axis_type = 8'h00;
        layout = 16'h0000;
        mode = MODE_CYCLIC;
        num = 24'h1;
        den = 24'h1;
        wr = 1'b0;
        ofs = 1'b0;
        dfn = 1'b0;
        pval = 32'h0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        t_ssi();
        t_bidir();
        t_other();
        t_scale();
        print_verdict();
    end
endmodule
